// >>> core/pcsr_regs.sv
/*
 * Command and status register bank with APB access, event flags,
 * error line drivers, decode gating and a maskable interrupt.
 * Assumes event inputs are one-cycle pulses from logic on mclk.
 */
// Local design decision: the APB interface to the registers.
module pcsr_regs
    import pcsr_pkg::*;
#(
    parameter logic [1:0] SEL_TIMING  = pcsr_pkg::PCSR_SEL_MEDIUM,
    parameter bit         FAST_CAP    = 1'b0,
    parameter bit         B2B_CAP     = 1'b0
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        data_parity_err,
    input  wire logic        addr_parity_err,
    input  wire logic        master_abort_evt,
    input  wire logic        abort_in_special,
    input  wire logic        target_abort_rcvd,
    input  wire logic        target_abort_sent,
    input  wire logic        master_perr_evt,
    input  wire logic        mem_decode_hit,
    input  wire logic        io_decode_hit,
    input  wire logic        special_cycle_seen,
    input  wire logic        master_req,
    input  wire logic        mwi_wanted,
    output logic             mem_claim,
    output logic             io_claim,
    output logic             special_cycle_take,
    output logic             master_req_out,
    output logic             use_mwi,
    output logic             write_invalidate_enable,
    output logic             special_cycle_monitor,
    output logic             master_enable,
    output logic             memory_decode_enable,
    output logic             io_decode_enable,
    output logic             parity_response_enable,
    output logic             system_error_driver_enable,
    output logic             serr_n_o,
    output logic             serr_n_oe,
    output logic             perr_n_o,
    output logic             perr_n_oe,
    output logic             irq
);

    import pcsr_pkg::*;

    // elaboration check on the timing code
    if (SEL_TIMING == 2'h3)
    begin : g_bad_timing
        $error("select timing code 11 is reserved");
    end

    typedef struct packed {
        logic [15:0]            cmd;
        logic                   parity_error_detected;
        logic                   system_error_signalled;
        logic                   master_abort_received;
        logic                   target_abort_received;
        logic                   target_abort_signalled;
        logic                   master_parity_error;
        logic [PCSR_IRQ_W-1:0]  irq_sts;
        logic [PCSR_IRQ_W-1:0]  irq_msk;
        logic [31:0]            rdata;
        logic                   err;
        logic                   serr_drv;
        logic                   perr_drv;
    } pcsr_state_s;

    pcsr_state_s s_q;
    pcsr_state_s s_d;
    logic        rst_q_n;
    logic [15:0] status_word;
    logic [PCSR_IRQ_W-1:0] ev;
    logic        wr_acc;
    logic        setup;

    // address match, used by read, write and error decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // byte-lane merge of a 16-bit register under a write mask
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0]  strb,
                                            input logic [15:0] msk);
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & msk;
        merge16 = (old & ~lane) | (nw & lane);
    endfunction

    pcsr_rst_sync u_rst_sync
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .rst_sync_n (rst_q_n)
    );

    // status word assembled from flags and fixed capability bits
    always_comb
    begin
        status_word = 16'h0000;
        status_word[PCSR_STS_DPE]  = s_q.parity_error_detected;
        status_word[PCSR_STS_SSE]  = s_q.system_error_signalled;
        status_word[PCSR_STS_RMA]  = s_q.master_abort_received;
        status_word[PCSR_STS_RTA]  = s_q.target_abort_received;
        status_word[PCSR_STS_STA]  = s_q.target_abort_signalled;
        status_word[PCSR_STS_SEL +: 2] = SEL_TIMING;
        status_word[PCSR_STS_MASTER_PARITY_ERROR] = s_q.master_parity_error;
        status_word[PCSR_STS_BACK_TO_BACK_CAPABLE] = B2B_CAP;
        status_word[PCSR_STS_FAST_CLOCK_CAPABLE] = FAST_CAP;
        status_word[PCSR_STS_CL]   = 1'b1;
    end

    // next state: events, bus writes, read capture
    always_comb
    begin
        s_d    = s_q;
        wr_acc = psel & penable & pwrite;
        setup  = psel & ~penable;
        // error lines: system error needs both enables, parity needs one
        s_d.serr_drv = addr_parity_err & s_q.cmd[PCSR_CMD_SYSTEM_ERROR_DRIVER_ENABLE]
                       & s_q.cmd[PCSR_CMD_PER];
        s_d.perr_drv = data_parity_err & s_q.cmd[PCSR_CMD_PER];
        // events that set sticky flags
        ev = '0;
        ev[PCSR_IRQ_DPE]  = data_parity_err | addr_parity_err;
        ev[PCSR_IRQ_SSE]  = s_d.serr_drv;
        ev[PCSR_IRQ_RMA]  = master_abort_evt & ~abort_in_special;
        ev[PCSR_IRQ_RTA]  = target_abort_rcvd;
        ev[PCSR_IRQ_STA]  = target_abort_sent;
        ev[PCSR_IRQ_MASTER_PARITY_ERROR] = master_perr_evt
                            & s_q.cmd[PCSR_CMD_PER];
        // flags only ever set, no bus path clears them
        s_d.parity_error_detected  = s_q.parity_error_detected  | ev[PCSR_IRQ_DPE];
        s_d.system_error_signalled  = s_q.system_error_signalled  | ev[PCSR_IRQ_SSE];
        s_d.master_abort_received  = s_q.master_abort_received  | ev[PCSR_IRQ_RMA];
        s_d.target_abort_received  = s_q.target_abort_received  | ev[PCSR_IRQ_RTA];
        s_d.target_abort_signalled  = s_q.target_abort_signalled  | ev[PCSR_IRQ_STA];
        s_d.master_parity_error = s_q.master_parity_error | ev[PCSR_IRQ_MASTER_PARITY_ERROR];
        // interrupt status: write one clears, a new event wins
        s_d.irq_sts = s_q.irq_sts | ev;
        if (wr_acc && hit(paddr, PCSR_IRQ_STS_ADDR) && pstrb[0])
        begin
            s_d.irq_sts = (s_q.irq_sts & ~pwdata[PCSR_IRQ_W-1:0]) | ev;
        end
        if (wr_acc && hit(paddr, PCSR_IRQ_MSK_ADDR) && pstrb[0])
        begin
            s_d.irq_msk = pwdata[PCSR_IRQ_W-1:0];
        end
        // command write, only the implemented enables change
        if (wr_acc && hit(paddr, PCSR_CMD_ADDR))
        begin
            s_d.cmd = merge16(s_q.cmd, pwdata[15:0], pstrb[1:0],
                              PCSR_CMD_WR_MASK);
        end
        // read data and error captured in the setup cycle
        if (setup)
        begin
            s_d.err   = 1'b0;
            s_d.rdata = 32'h0000_0000;
            if (hit(paddr, PCSR_CMD_ADDR))
            begin
                s_d.rdata[15:0] = s_q.cmd;
            end
            else if (hit(paddr, PCSR_STS_ADDR))
            begin
                s_d.rdata[15:0] = status_word;
            end
            else if (hit(paddr, PCSR_IRQ_STS_ADDR))
            begin
                s_d.rdata[PCSR_IRQ_W-1:0] = s_q.irq_sts;
            end
            else if (hit(paddr, PCSR_IRQ_MSK_ADDR))
            begin
                s_d.rdata[PCSR_IRQ_W-1:0] = s_q.irq_msk;
            end
            else
            begin
                s_d.err = 1'b1;
            end
        end
    end

    // state register, constants under reset
    always_ff @(posedge mclk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            s_q         <= '0;
            s_q.cmd     <= PCSR_CMD_RESET;
            s_q.irq_sts <= PCSR_IRQ_RESET;
            s_q.irq_msk <= PCSR_IRQ_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // bus answers: zero wait, data and error from flops
    assign pready  = 1'b1;
    assign prdata  = s_q.rdata;
    assign pslverr = s_q.err & psel & penable;

    // enable bits out
    assign write_invalidate_enable    = s_q.cmd[PCSR_CMD_MWI];
    assign special_cycle_monitor      = s_q.cmd[PCSR_CMD_SC];
    assign master_enable              = s_q.cmd[PCSR_CMD_BM];
    assign memory_decode_enable       = s_q.cmd[PCSR_CMD_MS];
    assign io_decode_enable           = s_q.cmd[PCSR_CMD_IOS];
    assign parity_response_enable     = s_q.cmd[PCSR_CMD_PER];
    assign system_error_driver_enable = s_q.cmd[PCSR_CMD_SYSTEM_ERROR_DRIVER_ENABLE];

    // gating of the engine's requests by the enables
    assign mem_claim          = mem_decode_hit & s_q.cmd[PCSR_CMD_MS];
    assign io_claim           = io_decode_hit & s_q.cmd[PCSR_CMD_IOS];
    assign special_cycle_take = special_cycle_seen
                                & s_q.cmd[PCSR_CMD_SC];
    assign master_req_out     = master_req & s_q.cmd[PCSR_CMD_BM];
    assign use_mwi            = master_req_out & mwi_wanted
                                & s_q.cmd[PCSR_CMD_MWI];

    // open-drain error lines, low when enabled
    assign serr_n_o  = 1'b0;
    assign serr_n_oe = s_q.serr_drv;
    assign perr_n_o  = 1'b0;
    assign perr_n_oe = s_q.perr_drv;

    // level interrupt from unmasked sticky bits
    assign irq = |(s_q.irq_sts & s_q.irq_msk);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_q_n);

    property p_mwi;
        use_mwi |-> write_invalidate_enable && master_enable;
    endproperty
    a_mwi: assert property (p_mwi) else $error("mwi used while off");

    property p_sc;
        special_cycle_take |-> special_cycle_seen && special_cycle_monitor;
    endproperty
    a_sc: assert property (p_sc) else $error("special cycle taken");

    property p_bm;
        master_req && !master_enable |-> !master_req_out;
    endproperty
    a_bm: assert property (p_bm) else $error("master without enable");

    property p_ms;
        mem_decode_hit |-> mem_claim == memory_decode_enable;
    endproperty
    a_ms: assert property (p_ms) else $error("memory claim wrong");

    property p_ios;
        io_claim |-> io_decode_hit && io_decode_enable;
    endproperty
    a_ios: assert property (p_ios) else $error("io claim wrong");

    property p_cmd_wr;
        wr_acc && paddr == PCSR_CMD_ADDR && pstrb[0]
            |=> master_enable == $past(pwdata[PCSR_CMD_BM]);
    endproperty
    a_cmd_wr: assert property (p_cmd_wr) else $error("command write lost");

    property p_sts_ro;
        wr_acc && paddr == PCSR_STS_ADDR && ev == '0
            |=> status_word == $past(status_word);
    endproperty
    a_sts_ro: assert property (p_sts_ro) else $error("status written");

    property p_fixed;
        status_word[PCSR_STS_SEL +: 2] == SEL_TIMING
            && status_word[PCSR_STS_CL];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status bits");

    property p_dpe;
        data_parity_err && !parity_response_enable
            |=> status_word[PCSR_STS_DPE] && !perr_n_oe;
    endproperty
    a_dpe: assert property (p_dpe) else $error("parity flag missed");

    property p_sse;
        $rose(serr_n_oe) |-> $rose(status_word[PCSR_STS_SSE])
            || $past(status_word[PCSR_STS_SSE]);
    endproperty
    a_sse: assert property (p_sse) else $error("system error flag");

    property p_rma;
        $rose(s_q.master_abort_received) |-> $past(master_abort_evt && !abort_in_special);
    endproperty
    a_rma: assert property (p_rma) else $error("master abort flag");

    property p_rta;
        target_abort_rcvd |=> status_word[PCSR_STS_RTA];
    endproperty
    a_rta: assert property (p_rta) else $error("target abort rcvd");

    property p_sta;
        target_abort_sent |=> status_word[PCSR_STS_STA] ##1 s_q.target_abort_signalled;
    endproperty
    a_sta: assert property (p_sta) else $error("target abort sent");

    property p_perr;
        perr_n_oe |-> $past(data_parity_err && parity_response_enable);
    endproperty
    a_perr: assert property (p_perr) else $error("parity line driven");

    property p_serr;
        serr_n_oe |-> $past(addr_parity_err && system_error_driver_enable
                             && parity_response_enable);
    endproperty
    a_serr: assert property (p_serr) else $error("system error driven");

    property p_master_parity_error;
        $rose(s_q.master_parity_error) |-> $past(master_perr_evt && parity_response_enable);
    endproperty
    a_master_parity_error: assert property (p_master_parity_error) else $error("master parity flag");

    property p_sticky;
        s_q.parity_error_detected && s_q.master_abort_received |=> s_q.parity_error_detected [*3] ##0 s_q.master_abort_received;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared");

endmodule

// >>> core/pcsr_pkg.sv
/*
 * Constants for the command and status register bank of a PCI attached
 * host controller: register indices and byte addresses, bit positions,
 * reset values, write masks and the interrupt bit layout.
 * Assumes an APB slave with 32-bit data and byte addresses on paddr.
 */
package pcsr_pkg;

    // register indices as printed, byte address is four times the index
    localparam logic [7:0]  PCSR_CMD_IDX      = 8'h04;
    localparam logic [7:0]  PCSR_STS_IDX      = 8'h06;
    localparam logic [7:0]  PCSR_CMD_ADDR     = 8'(PCSR_CMD_IDX * 4);
    localparam logic [7:0]  PCSR_STS_ADDR     = 8'(PCSR_STS_IDX * 4);
    localparam logic [7:0]  PCSR_IRQ_STS_ADDR = 8'h20;
    localparam logic [7:0]  PCSR_IRQ_MSK_ADDR = 8'h24;

    // command bit positions
    localparam int PCSR_CMD_IOS   = 0;
    localparam int PCSR_CMD_MS    = 1;
    localparam int PCSR_CMD_BM    = 2;
    localparam int PCSR_CMD_SC    = 3;
    localparam int PCSR_CMD_MWI   = 4;
    localparam int PCSR_CMD_PER   = 6;
    localparam int PCSR_CMD_SYSTEM_ERROR_DRIVER_ENABLE = 8;

    // writable command bits and reset value
    localparam logic [15:0] PCSR_CMD_WR_MASK = 16'h015F;
    localparam logic [15:0] PCSR_CMD_RESET   = 16'h0000;

    // status bit positions
    localparam int PCSR_STS_DPE   = 15;
    localparam int PCSR_STS_SSE   = 14;
    localparam int PCSR_STS_RMA   = 13;
    localparam int PCSR_STS_RTA   = 12;
    localparam int PCSR_STS_STA   = 11;
    localparam int PCSR_STS_SEL   = 9;
    localparam int PCSR_STS_MASTER_PARITY_ERROR  = 8;
    localparam int PCSR_STS_BACK_TO_BACK_CAPABLE  = 7;
    localparam int PCSR_STS_FAST_CLOCK_CAPABLE  = 5;
    localparam int PCSR_STS_CL    = 4;

    // status constants after reset
    localparam logic [1:0]  PCSR_SEL_MEDIUM = 2'h1;
    localparam logic [15:0] PCSR_STS_RESET  = 16'h0210;

    // interrupt status and mask layout, one bit per event
    localparam int PCSR_IRQ_W    = 6;
    localparam int PCSR_IRQ_DPE  = 0;
    localparam int PCSR_IRQ_SSE  = 1;
    localparam int PCSR_IRQ_RMA  = 2;
    localparam int PCSR_IRQ_RTA  = 3;
    localparam int PCSR_IRQ_STA  = 4;
    localparam int PCSR_IRQ_MASTER_PARITY_ERROR = 5;
    localparam logic [PCSR_IRQ_W-1:0] PCSR_IRQ_RESET = 6'h00;

endpackage

// >>> core/pcsr_rst_sync.sv
/*
 * Reset release synchroniser: asserts at once, releases after two edges.
 * Assumes rst_n may change at any time relative to mclk.
 */
module pcsr_rst_sync
(
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      rst_sync_n
);

    logic [1:0] sync_q;

    // two stage release, constants only under reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_q <= 2'h0;
        end
        else
        begin
            sync_q <= {sync_q[0], 1'b1};
        end
    end

    assign rst_sync_n = sync_q[1];

endmodule

// >>> bench/pcsr_events_model.sv
/*
 * Far side bus engine model: raises bus event pulses for one cycle.
 * Assumes the bench calls pulse and that mclk is the register clock.
 */
module pcsr_events_model
(
    input  wire logic mclk,
    output logic      data_parity_err,
    output logic      addr_parity_err,
    output logic      master_abort_evt,
    output logic      abort_in_special,
    output logic      target_abort_rcvd,
    output logic      target_abort_sent,
    output logic      master_perr_evt
);
    timeunit 1ns;
    timeprecision 1ns;

    // all events idle until asked for
    initial
    begin
        {master_perr_evt, target_abort_sent, target_abort_rcvd,
         abort_in_special, master_abort_evt, addr_parity_err,
         data_parity_err} = '0;
    end

    // one-cycle pulse, launched and dropped right after rising edges
    task automatic pulse(input logic [6:0] v);
        @(posedge mclk);
        {master_perr_evt, target_abort_sent, target_abort_rcvd,
         abort_in_special, master_abort_evt, addr_parity_err,
         data_parity_err} <= v;
        @(posedge mclk);
        {master_perr_evt, target_abort_sent, target_abort_rcvd,
         abort_in_special, master_abort_evt, addr_parity_err,
         data_parity_err} <= '0;
    endtask
endmodule

// >>> bench/pcsr_regs_bench.sv
/*
 * Self-checking bench for the command and status register bank.
 * Assumes pcsr_pkg, pcsr_regs and pcsr_events_model are compiled first.
 */
module pcsr_regs_bench;
    import pcsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed
    {
        logic [31:0] d;
        logic        e;
        logic        w;
    } pcsr_note_s;

    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, lfsr_q;
    logic [3:0]  pstrb;
    logic        mem_decode_hit, io_decode_hit, special_cycle_seen;
    logic        master_req, mwi_wanted, mem_claim, io_claim, use_mwi;
    logic        special_cycle_take, master_req_out;
    logic        write_invalidate_enable, special_cycle_monitor;
    logic        master_enable, memory_decode_enable, io_decode_enable;
    logic        parity_response_enable, system_error_driver_enable;
    logic        serr_n_o, serr_n_oe, perr_n_o, perr_n_oe;
    logic        data_parity_err, addr_parity_err, master_abort_evt;
    logic        abort_in_special, target_abort_rcvd, target_abort_sent;
    logic        master_perr_evt;
    int          mismatches, n_checks;
    pcsr_note_s  notes[$];
    pcsr_note_s  cur_note;

    pcsr_regs u_pcsr_regs
    (
        .mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .data_parity_err, .addr_parity_err,
        .master_abort_evt, .abort_in_special, .target_abort_rcvd,
        .target_abort_sent, .master_perr_evt, .mem_decode_hit,
        .io_decode_hit, .special_cycle_seen, .master_req, .mwi_wanted,
        .mem_claim, .io_claim, .special_cycle_take, .master_req_out,
        .use_mwi, .write_invalidate_enable, .special_cycle_monitor,
        .master_enable, .memory_decode_enable, .io_decode_enable,
        .parity_response_enable, .system_error_driver_enable, .serr_n_o,
        .serr_n_oe, .perr_n_o, .perr_n_oe, .irq
    );

    pcsr_events_model u_pcsr_events_model
    (
        .mclk, .data_parity_err, .addr_parity_err, .master_abort_evt,
        .abort_in_special, .target_abort_rcvd, .target_abort_sent,
        .master_perr_evt
    );

    // 100 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [6:0] ens();
        return {system_error_driver_enable, parity_response_enable,
                write_invalidate_enable, special_cycle_monitor,
                master_enable, memory_decode_enable, io_decode_enable};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // apb transfer, expected answer noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e,
                       input logic err);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        notes.push_back('{d: e, e: err, w: w});
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
        begin
            @(posedge mclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // random engine requests against the command gating
    task automatic claims(input logic [15:0] c);
        repeat (6)
        begin
            @(posedge mclk);
            lfsr_q = lfsr_next(lfsr_q);
            {mem_decode_hit, io_decode_hit, special_cycle_seen, master_req,
             mwi_wanted} <= lfsr_q[4:0];
            @(negedge mclk);
            chk("claims", 32'({mem_claim, io_claim, special_cycle_take,
                master_req_out, use_mwi}), 32'({lfsr_q[4] & c[1],
                lfsr_q[3] & c[0], lfsr_q[2] & c[3], lfsr_q[1] & c[2],
                lfsr_q[1] & c[2] & lfsr_q[0] & c[4]}));
        end
    endtask

    // event pulse, then error line drivers for one cycle only
    task automatic ev(input logic [6:0] v, input logic s, input logic p);
        u_pcsr_events_model.pulse(v);
        #1;
        chk("serr_oe", 32'(serr_n_oe), 32'(s));
        chk("line_lvl", 32'({serr_n_o, perr_n_o}), 32'h0);
        if (p !== 1'bx)
            chk("perr_oe", 32'(perr_n_oe), 32'(p));
        @(posedge mclk);
        #1;
        chk("oe_pulse", 32'({serr_n_oe, perr_n_oe}), 32'h0);
    endtask

    // monitor: answers at completion edges against oldest note
    always @(posedge mclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            cur_note = notes.pop_front();
            chk("pslverr", 32'(pslverr), 32'(cur_note.e));
            if (!cur_note.w)
                chk("prdata", prdata, cur_note.d);
        end
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    // main sequence
    initial
    begin
        mismatches = 0;
        n_checks   = 0;
        lfsr_q     = 32'h0724;
        rst_n      = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb      = 4'hF;
        {mem_decode_hit, io_decode_hit, special_cycle_seen, master_req,
         mwi_wanted} = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("enables", 32'(ens()), 32'h0);
        apb(1'b0, PCSR_CMD_ADDR, 32'h0, 32'h0, 1'b0);
        apb(1'b0, PCSR_STS_ADDR, 32'h0, 32'h0210, 1'b0);
        claims(16'h0000);
        apb(1'b1, PCSR_CMD_ADDR, 32'hFFFF, 32'h0, 1'b0);
        apb(1'b0, PCSR_CMD_ADDR, 32'h0, 32'h015F, 1'b0);
        chk("enables", 32'(ens()), 32'h7F);
        claims(16'h015F);
        apb(1'b1, PCSR_STS_ADDR, 32'hFFFF, 32'h0, 1'b0);
        apb(1'b0, PCSR_STS_ADDR, 32'h0, 32'h0210, 1'b0);
        // parity response off: flag only, lines idle
        apb(1'b1, PCSR_CMD_ADDR, 32'h0, 32'h0, 1'b0);
        ev(7'h02, 1'b0, 1'b0);
        ev(7'h01, 1'b0, 1'b0);
        ev(7'h0C, 1'b0, 1'b0);
        ev(7'h40, 1'b0, 1'b0);
        apb(1'b0, PCSR_STS_ADDR, 32'h0, 32'h8210, 1'b0);
        // parity response and system error driver on
        apb(1'b1, PCSR_CMD_ADDR, 32'h0140, 32'h0, 1'b0);
        ev(7'h01, 1'b0, 1'b1);
        ev(7'h02, 1'b1, 1'bx);
        ev(7'h04, 1'b0, 1'b0);
        ev(7'h10, 1'b0, 1'b0);
        ev(7'h20, 1'b0, 1'b0);
        ev(7'h40, 1'b0, 1'b0);
        apb(1'b0, PCSR_STS_ADDR, 32'h0, 32'hFB10, 1'b0);
        apb(1'b1, PCSR_STS_ADDR, 32'h0, 32'h0, 1'b0);
        apb(1'b0, PCSR_STS_ADDR, 32'h0, 32'hFB10, 1'b0);
        // interrupt: masked, unmasked, cleared
        chk("irq", 32'(irq), 32'h0);
        apb(1'b0, PCSR_IRQ_STS_ADDR, 32'h0, 32'h3F, 1'b0);
        apb(1'b1, PCSR_IRQ_MSK_ADDR, 32'h10, 32'h0, 1'b0);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, PCSR_IRQ_STS_ADDR, 32'h10, 32'h0, 1'b0);
        chk("irq", 32'(irq), 32'h0);
        apb(1'b0, PCSR_IRQ_STS_ADDR, 32'h0, 32'h2F, 1'b0);
        apb(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
        // second reset clears the sticky flags and enables
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, PCSR_STS_ADDR, 32'h0, 32'h0210, 1'b0);
        apb(1'b0, PCSR_CMD_ADDR, 32'h0, 32'h0, 1'b0);
        chk("enables", 32'(ens()), 32'h0);
        repeat (2) @(posedge mclk);
        conclude();
    end
endmodule
